// ===== logic/sitc_regs.vh
`ifndef SITC_REGS_VH
`define SITC_REGS_VH

// ==========================================
// Register indices (byte address = index * 4)
`define SITC_IDX_SEL 30'h00800102
`define SITC_IDX_TXC0 30'h00800110
`define SITC_IDX_TXC1 30'h00800120
`define SITC_IDX_TXC2 30'h00800130
`define SITC_IDX_MASK 30'h00800103
`define SITC_IDX_EVST 30'h00800104
`define SITC_IDX_EVMK 30'h00800105

// ==========================================
// Reset values
`define SITC_RST_SEL 8'h00
`define SITC_RST_TXC 8'h12
`define SITC_RST_MASK 8'h00
`define SITC_RST_EV 8'h00

// ==========================================
// Transmit control fields
`define SITC_TXC_TEN 0
`define SITC_TXC_TBE 1
`define SITC_TXC_TRANSMIT_ACTIVE_FLAG 2
`define SITC_TXC_COUNT_SOURCE_SELECT_LO 4
`define SITC_TXC_COUNT_SOURCE_SELECT_HI 5

// ==========================================
// Mask fields: tx of channel n at bit 7-2n, rx at bit 6-2n
`define SITC_MASK_TX_TOP 7
`define SITC_MASK_RX_TOP 6
`define SITC_MASK_USED 8'hfc

// ==========================================
// Cause select: channel n at bit 3-n, 1 = error cause
`define SITC_SEL_TOP 3
`define SITC_SEL_USED 8'h0e

// ==========================================
// Event status / mask: tx of channel n at bit n, rx at bit 3+n
`define SITC_EV_RX_BASE 3
`define SITC_EV_USED 8'h3f

// ==========================================
// Count source divisors, as last count value
`define SITC_DIV1_LAST 8'h00
`define SITC_DIV8_LAST 8'h07
`define SITC_DIV32_LAST 8'h1f
`define SITC_DIV256_LAST 8'hff

// ==========================================
// Bus responses
`define SITC_RESP_OKAY 2'h0
`define SITC_RESP_SLVERR 2'h2

`endif

// ===== logic/sitc_txch.v
`default_nettype none
`include "sitc_regs.vh"

module sitc_txch (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control register access
	input wire ctl_wr,
	input wire [7:0] ctl_wdata,
	output wire [7:0] ctl_rdata,
	// Transmit path
	input wire txb_wr_lo,
	input wire tx_shift_done,
	output reg tx_load,
	output wire tx_enable,
	output wire tx_buffer_empty_flag,
	// Baud generator count source
	output reg brg_tick
);

	reg ten_q, tbe_q, transmit_active_flag_q, buf_full_q, shift_busy_q;
	reg [1:0] count_source_select_q;
	reg [7:0] pre_q;
	wire wr_ok;
	wire load;
	wire ten_clr;
	wire [7:0] last;
	wire [7:0] rst_txc;

	assign rst_txc = `SITC_RST_TXC;

	// ==========================================
	// Count source prescaler
	function [7:0] div_last;
		input [1:0] code;
		begin
			case (code)
				2'h0: div_last = `SITC_DIV1_LAST;
				2'h1: div_last = `SITC_DIV8_LAST;
				2'h2: div_last = `SITC_DIV32_LAST;
				default: div_last = `SITC_DIV256_LAST;
			endcase
		end
	endfunction

	assign last = div_last(count_source_select_q);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 8'h00;
			brg_tick <= 1'b0;
		end else if (pre_q >= last) begin
			pre_q <= 8'h00; // RULE6
			brg_tick <= 1'b1;
		end else begin
			pre_q <= pre_q + 8'h01;
			brg_tick <= 1'b0;
		end
	end

	// ==========================================
	// Transmit buffer and shifter tracking
	assign wr_ok = txb_wr_lo & ten_q; // RULE14
	assign load = buf_full_q & ~shift_busy_q & ten_q;
	assign ten_clr = ctl_wr & ~ctl_wdata[`SITC_TXC_TEN];

	always @(posedge aclk) begin
		if (!aresetn) begin
			ten_q <= rst_txc[`SITC_TXC_TEN];
			tbe_q <= rst_txc[`SITC_TXC_TBE];
			transmit_active_flag_q <= rst_txc[`SITC_TXC_TRANSMIT_ACTIVE_FLAG];
			count_source_select_q <= rst_txc[`SITC_TXC_COUNT_SOURCE_SELECT_HI:`SITC_TXC_COUNT_SOURCE_SELECT_LO];
			buf_full_q <= 1'b0;
			shift_busy_q <= 1'b0;
			tx_load <= 1'b0;
		end else begin
			tx_load <= 1'b0;
			if (ctl_wr) begin
				ten_q <= ctl_wdata[`SITC_TXC_TEN];
				count_source_select_q <= ctl_wdata[`SITC_TXC_COUNT_SOURCE_SELECT_HI:`SITC_TXC_COUNT_SOURCE_SELECT_LO];
			end
			if (ten_clr || !ten_q) begin
				tbe_q <= 1'b1; // RULE10
				transmit_active_flag_q <= 1'b0; // RULE9
				buf_full_q <= 1'b0; // RULE12
				shift_busy_q <= 1'b0; // RULE12
			end else begin
				if (load) begin
					tx_load <= 1'b1;
					shift_busy_q <= 1'b1;
					buf_full_q <= 1'b0;
					tbe_q <= 1'b1; // RULE10
				end else if (tx_shift_done) begin
					shift_busy_q <= 1'b0;
				end
				if (wr_ok) begin
					buf_full_q <= 1'b1;
					tbe_q <= 1'b0; // RULE11
					transmit_active_flag_q <= 1'b1; // RULE8
				end else if (!buf_full_q && !load && (!shift_busy_q || tx_shift_done)) begin
					transmit_active_flag_q <= 1'b0; // RULE9
				end
			end
		end
	end

	assign tx_enable = ten_q; // RULE12
	assign tx_buffer_empty_flag = tbe_q;
	assign ctl_rdata = {2'h0, count_source_select_q, 1'b0, transmit_active_flag_q, tbe_q, ten_q};

endmodule

`default_nettype wire

// ===== logic/sitc_top.v
// Contract
// [RULE1] Request passes only while mask bit is 1
// [RULE2] Mask bits tx/rx per channel, 2-7
// [RULE3] Cause select bit per channel, 0=finished
// [RULE4] Finished cause: done, parity, framing, no overrun
// [RULE5] Error cause: overrun always, parity/framing in UART
// [RULE6] Count source divides clock 1/8/32/256
// [RULE7] Software keeps baud within maximum at /1
// [RULE8] Accepted buffer write sets transmit-active flag
// [RULE9] Active flag clears when idle or disabled
// [RULE10] Empty flag sets on load or disable
// [RULE11] Empty flag clears on enabled buffer write
// [RULE12] Enable bit gates and stops transmission
// [RULE13] No request without enable and mask
// [RULE14] Buffer write while disabled is ignored
// [RULE15] Channel 2 tx and rx merged
// [RULE16] Tx request is empty AND enable, masked
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none
`include "sitc_regs.vh"

module sitc_top (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Transmit side, one bit per channel
	input wire [2:0] txb_wr_lo,
	input wire [2:0] tx_shift_done,
	output wire [2:0] tx_load,
	output wire [2:0] tx_enable,
	output wire [2:0] brg_tick,
	// Receive side, one bit per channel
	input wire [2:0] rx_enable,
	input wire [2:0] clock_synchronous_mode,
	input wire [2:0] rx_done,
	input wire [2:0] rx_err_overrun,
	input wire [2:0] rx_err_parity,
	input wire [2:0] rx_err_framing,
	// Interrupt controller lines
	output reg irq_tx_ch0,
	output reg irq_rx_ch0,
	output reg irq_tx_ch1,
	output reg irq_rx_ch1,
	output reg irq_grp_ch2,
	// Summary interrupt
	output wire irq
);

	// ==========================================
	// Register bank state
	reg [7:0] sel_q;
	reg [7:0] mask_q;
	reg [7:0] evst_q;
	reg [7:0] evmk_q;
	reg [2:0] tx_req_q;

	// ==========================================
	// AXI4-Lite slave state
	reg aw_full_q;
	reg w_full_q;
	reg [29:0] aw_idx_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire wr_fire;
	wire wr_lane0;
	wire rd_fire;
	wire [29:0] ar_idx;
	reg [7:0] rd_byte;
	reg rd_hit;

	wire [7:0] txc_rdata0, txc_rdata1, txc_rdata2;
	wire [2:0] tx_buffer_empty_flag;
	wire [2:0] txc_wr;
	reg [2:0] tx_req_d;
	reg [2:0] rx_req_d;
	reg [7:0] ev_set;
	integer i;
	integer j;

	// ==========================================
	// Address decode helpers
	function is_mapped;
		input [29:0] idx;
		begin
			case (idx)
				`SITC_IDX_SEL,
				`SITC_IDX_TXC0,
				`SITC_IDX_TXC1,
				`SITC_IDX_TXC2,
				`SITC_IDX_MASK,
				`SITC_IDX_EVST,
				`SITC_IDX_EVMK: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	function reg_wr;
		input [29:0] idx;
		input [29:0] target;
		begin
			reg_wr = wr_fire && wr_lane0 && (idx == target);
		end
	endfunction

	// ==========================================
	// Write channel: address and data in either order
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_lane0 = wstrb_q[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_idx_q <= 30'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SITC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[31:2];
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_idx_q) ? `SITC_RESP_OKAY : `SITC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
	assign ar_idx = s_axi_araddr[31:2];

	always @* begin
		rd_hit = 1'b1;
		case (ar_idx)
			`SITC_IDX_SEL: rd_byte = sel_q & `SITC_SEL_USED;
			`SITC_IDX_TXC0: rd_byte = txc_rdata0;
			`SITC_IDX_TXC1: rd_byte = txc_rdata1;
			`SITC_IDX_TXC2: rd_byte = txc_rdata2;
			`SITC_IDX_MASK: rd_byte = mask_q & `SITC_MASK_USED; // RULE2
			`SITC_IDX_EVST: rd_byte = evst_q & `SITC_EV_USED;
			`SITC_IDX_EVMK: rd_byte = evmk_q & `SITC_EV_USED;
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SITC_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, rd_byte};
			s_axi_rresp <= rd_hit ? `SITC_RESP_OKAY : `SITC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// Mask and cause select registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= `SITC_RST_SEL;
			mask_q <= `SITC_RST_MASK;
			evmk_q <= `SITC_RST_EV;
		end else begin
			if (reg_wr(aw_idx_q, `SITC_IDX_SEL))
				sel_q <= wdata_q[7:0] & `SITC_SEL_USED; // RULE3
			if (reg_wr(aw_idx_q, `SITC_IDX_MASK))
				mask_q <= wdata_q[7:0] & `SITC_MASK_USED; // RULE2
			if (reg_wr(aw_idx_q, `SITC_IDX_EVMK))
				evmk_q <= wdata_q[7:0] & `SITC_EV_USED;
		end
	end

	// ==========================================
	// Transmit channels
	assign txc_wr[0] = reg_wr(aw_idx_q, `SITC_IDX_TXC0);
	assign txc_wr[1] = reg_wr(aw_idx_q, `SITC_IDX_TXC1);
	assign txc_wr[2] = reg_wr(aw_idx_q, `SITC_IDX_TXC2);

	sitc_txch u_tx0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl_wr(txc_wr[0]),
		.ctl_wdata(wdata_q[7:0]),
		.ctl_rdata(txc_rdata0),
		.txb_wr_lo(txb_wr_lo[0]),
		.tx_shift_done(tx_shift_done[0]),
		.tx_load(tx_load[0]),
		.tx_enable(tx_enable[0]),
		.tx_buffer_empty_flag(tx_buffer_empty_flag[0]),
		.brg_tick(brg_tick[0])
	);

	sitc_txch u_tx1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl_wr(txc_wr[1]),
		.ctl_wdata(wdata_q[7:0]),
		.ctl_rdata(txc_rdata1),
		.txb_wr_lo(txb_wr_lo[1]),
		.tx_shift_done(tx_shift_done[1]),
		.tx_load(tx_load[1]),
		.tx_enable(tx_enable[1]),
		.tx_buffer_empty_flag(tx_buffer_empty_flag[1]),
		.brg_tick(brg_tick[1])
	);

	sitc_txch u_tx2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl_wr(txc_wr[2]),
		.ctl_wdata(wdata_q[7:0]),
		.ctl_rdata(txc_rdata2),
		.txb_wr_lo(txb_wr_lo[2]),
		.tx_shift_done(tx_shift_done[2]),
		.tx_load(tx_load[2]),
		.tx_enable(tx_enable[2]),
		.tx_buffer_empty_flag(tx_buffer_empty_flag[2]),
		.brg_tick(brg_tick[2])
	);

	// ==========================================
	// Request generation per channel
	always @* begin
		for (i = 0; i < 3; i = i + 1) begin
			tx_req_d[i] = tx_buffer_empty_flag[i] & tx_enable[i] & mask_q[`SITC_MASK_TX_TOP - 2 * i]; // RULE16 RULE1 RULE13
			if (sel_q[`SITC_SEL_TOP - i])
				rx_req_d[i] = rx_err_overrun[i] |
					(~clock_synchronous_mode[i] & (rx_err_parity[i] | rx_err_framing[i])); // RULE5
			else
				rx_req_d[i] = rx_done[i] | rx_err_parity[i] | rx_err_framing[i]; // RULE4
			rx_req_d[i] = rx_req_d[i] & rx_enable[i] & mask_q[`SITC_MASK_RX_TOP - 2 * i]; // RULE1 RULE13
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_req_q <= 3'h0;
			irq_tx_ch0 <= 1'b0;
			irq_rx_ch0 <= 1'b0;
			irq_tx_ch1 <= 1'b0;
			irq_rx_ch1 <= 1'b0;
			irq_grp_ch2 <= 1'b0;
		end else begin
			tx_req_q <= tx_req_d;
			irq_tx_ch0 <= tx_req_d[0];
			irq_rx_ch0 <= rx_req_d[0];
			irq_tx_ch1 <= tx_req_d[1];
			irq_rx_ch1 <= rx_req_d[1];
			irq_grp_ch2 <= tx_req_d[2] | rx_req_d[2]; // RULE15
		end
	end

	// ==========================================
	// Sticky event status, write one to clear
	always @* begin
		ev_set = 8'h00;
		for (j = 0; j < 3; j = j + 1) begin
			ev_set[j] = tx_req_d[j] & ~tx_req_q[j];
			ev_set[`SITC_EV_RX_BASE + j] = rx_req_d[j];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			evst_q <= `SITC_RST_EV;
		else if (reg_wr(aw_idx_q, `SITC_IDX_EVST))
			evst_q <= ((evst_q & ~wdata_q[7:0]) | ev_set) & `SITC_EV_USED;
		else
			evst_q <= (evst_q | ev_set) & `SITC_EV_USED;
	end

	assign irq = |(evst_q & evmk_q);

endmodule

`default_nettype wire

// ===== sim/sitc_top_sva.sv
`default_nettype none
module sitc_top_sva (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Channel side
	input wire logic [2:0] tx_load,
	input wire logic [2:0] tx_enable,
	input wire logic [2:0] rx_enable,
	input wire logic [2:0] rx_done,
	input wire logic [2:0] rx_err_overrun,
	input wire logic [2:0] rx_err_parity,
	input wire logic [2:0] rx_err_framing,
	input wire logic irq_tx_ch0,
	input wire logic irq_tx_ch1,
	input wire logic irq_rx_ch0,
	input wire logic irq_grp_ch2
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Transmit and interrupt gating
	AST_LOAD_EN: assert property (tx_load[0] |-> $past(tx_enable[0])) else $error("load while disabled");
	AST_RST_TEN: assert property ($rose(aresetn) |-> tx_enable == 3'h0) else $error("enable after reset");
	AST_TX0_EN: assert property (irq_tx_ch0 |-> $past(tx_enable[0])) else $error("tx0 request unenabled");
	AST_TX1_EN: assert property (irq_tx_ch1 |-> $past(tx_enable[1])) else $error("tx1 request unenabled");
	AST_RX_CAUSE: assert property (irq_rx_ch0 |-> $past(rx_done[0] | rx_err_overrun[0] | rx_err_parity[0]
		| rx_err_framing[0])) else $error("rx request without event");
	AST_RX_EN: assert property (irq_rx_ch0 |-> $past(rx_enable[0])) else $error("rx request unenabled");
	AST_GRP: assert property (irq_grp_ch2 |-> $past(tx_enable[2] | rx_enable[2])) else $error("group unenabled");
	// ==========================================
	// Bus answers stand
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule
`default_nettype wire

// ===== sim/sitc_shift_model.sv
`default_nettype none
module sitc_shift_model #(
	parameter int FRAME = 40
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Shifter side
	input wire logic [2:0] tx_load,
	input wire logic [2:0] tx_enable,
	output logic [2:0] tx_shift_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt [3];
	always @(posedge aclk) begin
		for (int i = 0; i < 3; i++) begin
			tx_shift_done[i] <= 1'b0;
			if (!aresetn || !tx_enable[i]) begin
				cnt[i] <= 0;
			end else if (tx_load[i]) begin
				cnt[i] <= FRAME;
			end else if (cnt[i] == 1) begin
				cnt[i] <= 0;
				tx_shift_done[i] <= 1'b1;
			end else if (cnt[i] > 1) begin
				cnt[i] <= cnt[i] - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`default_nettype none
`include "sitc_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] A_SEL = {`SITC_IDX_SEL, 2'h0};
	localparam logic [31:0] A_MASK = {`SITC_IDX_MASK, 2'h0};
	localparam logic [31:0] A_EVST = {`SITC_IDX_EVST, 2'h0};
	localparam logic [31:0] A_EVMK = {`SITC_IDX_EVMK, 2'h0};
	localparam logic [31:0] A_TX [3] = '{{`SITC_IDX_TXC0, 2'h0}, {`SITC_IDX_TXC1, 2'h0}, {`SITC_IDX_TXC2, 2'h0}};
	localparam int DIVS [4] = '{1, 8, 32, 256};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic [2:0] txb_wr_lo = '0, rx_enable = '0, clock_synchronous_mode = '0;
	logic [2:0] rx_done = '0, rx_err_overrun = '0, rx_err_parity = '0, rx_err_framing = '0;
	wire logic [2:0] tx_shift_done, tx_load, tx_enable, brg_tick;
	wire logic irq_tx_ch0, irq_rx_ch0, irq_tx_ch1, irq_rx_ch1, irq_grp_ch2, irq;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [33:0] exp_q [$];
	logic [31:0] seed = 32'he2448a9f;
	logic [1:0] last_b;
	always #20 aclk = ~aclk;
	sitc_top sitc_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.txb_wr_lo(txb_wr_lo), .tx_shift_done(tx_shift_done), .tx_load(tx_load),
		.tx_enable(tx_enable), .brg_tick(brg_tick), .rx_enable(rx_enable),
		.clock_synchronous_mode(clock_synchronous_mode), .rx_done(rx_done),
		.rx_err_overrun(rx_err_overrun), .rx_err_parity(rx_err_parity), .rx_err_framing(rx_err_framing),
		.irq_tx_ch0(irq_tx_ch0), .irq_rx_ch0(irq_rx_ch0), .irq_tx_ch1(irq_tx_ch1),
		.irq_rx_ch1(irq_rx_ch1), .irq_grp_ch2(irq_grp_ch2), .irq(irq));
	sitc_shift_model #(.FRAME(40)) sitc_shift_model_inst (.aclk(aclk), .aresetn(aresetn), .tx_load(tx_load),
		.tx_enable(tx_enable), .tx_shift_done(tx_shift_done));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [33:0] got, input logic [33:0] want);
		n_checks++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================
	// Timeout and read-answer scoreboard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		last_b = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] rs = 2'h0);
		exp_q.push_back({rs, 24'h0, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	task txw();
		txb_wr_lo <= 3'h1;
		@(posedge aclk);
		txb_wr_lo <= 3'h0;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] r;
		int n;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(A_SEL, 8'h00);
		for (int i = 0; i < 3; i++) rd(A_TX[i], 8'h12);
		rd(A_MASK, 8'h00);
		rd(A_EVST, 8'h00);
		rd(A_EVMK, 8'h00);
		rd(32'h02000418, 8'h00, 2'h2);
		wr(32'h02000418, 8'hff);
		chk(last_b, 2'h2);
		for (int i = 0; i < 9; i++) begin
			r = xs();
			wr(A_MASK, r[7:0]);
			rd(A_MASK, r[7:0] & 8'hfc);
			wr(A_SEL, r[15:8]);
			rd(A_SEL, r[15:8] & 8'h0e);
			wr(A_TX[i % 3], r[23:16]);
			rd(A_TX[i % 3], (r[23:16] & 8'h31) | 8'h02);
		end
		$display("registers done");
		for (int c = 0; c < 4; c++) begin
			wr(A_TX[c % 3], {2'h0, c[1:0], 4'h0});
			repeat (2) begin
				@(posedge aclk);
				while (!brg_tick[c % 3]) @(posedge aclk);
			end
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!brg_tick[c % 3]);
			chk(n, DIVS[c]);
		end
		$display("count source done");
		wr(A_TX[0], 8'h11);
		txw();
		repeat (2) @(posedge aclk);
		chk(tx_load[0], 1'b1);
		rd(A_TX[0], 8'h17);
		txw();
		rd(A_TX[0], 8'h15);
		repeat (150) @(posedge aclk);
		rd(A_TX[0], 8'h13);
		txw();
		wr(A_TX[0], 8'h10);
		rd(A_TX[0], 8'h12);
		chk(tx_enable[0], 1'b0);
		txw();
		rd(A_TX[0], 8'h12);
		$display("transmit done");
		wr(A_MASK, 8'h88);
		wr(A_TX[0], 8'h11);
		wr(A_TX[2], 8'h11);
		chk(irq_tx_ch0, 1'b1);
		chk(irq_grp_ch2, 1'b1);
		wr(A_TX[0], 8'h10);
		chk(irq_tx_ch0, 1'b0);
		wr(A_MASK, 8'h00);
		chk(irq_grp_ch2, 1'b0);
		for (int i = 0; i < 32; i++) begin
			r = xs();
			wr(A_SEL, {4'h0, r[0], 3'h0});
			wr(A_MASK, {1'b0, r[6], 6'h0});
			rx_enable <= {2'h0, r[7]};
			clock_synchronous_mode <= {2'h0, r[1]};
			rx_done <= {2'h0, r[2]};
			rx_err_overrun <= {2'h0, r[3]};
			rx_err_parity <= {2'h0, r[4]};
			rx_err_framing <= {2'h0, r[5]};
			@(posedge aclk);
			rx_done <= '0;
			rx_err_overrun <= '0;
			rx_err_parity <= '0;
			rx_err_framing <= '0;
			@(posedge aclk);
			chk(irq_rx_ch0, r[6] & r[7] & (r[0] ? r[3] | (!r[1] & (r[4] | r[5])) : r[2] | r[4] | r[5]));
		end
		wr(A_MASK, 8'h30);
		wr(A_TX[1], 8'h11);
		chk(irq_tx_ch1, 1'b1);
		rx_enable <= 3'h2;
		rx_done <= 3'h2;
		@(posedge aclk);
		rx_done <= 3'h0;
		@(posedge aclk);
		chk(irq_rx_ch1, 1'b1);
		$display("receive cause done");
		wr(A_EVST, 8'h3f);
		wr(A_EVMK, 8'h08);
		wr(A_MASK, 8'h40);
		wr(A_SEL, 8'h00);
		rx_enable <= 3'h1;
		rx_done <= 3'h1;
		@(posedge aclk);
		rx_done <= 3'h0;
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		wr(A_EVMK, 8'h00);
		chk(irq, 1'b0);
		wr(A_EVMK, 8'h08);
		rd(A_EVST, 8'h08);
		wr(A_EVST, 8'h08);
		chk(irq, 1'b0);
		$display("interrupt status done");
		print_verdict();
	end
endmodule
bind sitc_top sitc_top_sva sitc_top_sva_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.tx_load(tx_load), .tx_enable(tx_enable), .rx_enable(rx_enable), .rx_done(rx_done),
	.rx_err_overrun(rx_err_overrun), .rx_err_parity(rx_err_parity), .rx_err_framing(rx_err_framing),
	.irq_tx_ch0(irq_tx_ch0), .irq_tx_ch1(irq_tx_ch1), .irq_rx_ch0(irq_rx_ch0), .irq_grp_ch2(irq_grp_ch2));
`default_nettype wire
